// ===== hdl/rbm_pkg.sv
// Constants and types for the reset and boot-source selection block.
// Assumes a 100 MHz ref_clk and an external pull-up or flash on the strap line.
package rbm_pkg;

  localparam int CLK_MHZ = 100;

  // Internal start-up delay after the reset pin rises, in ns
  localparam int STARTUP_NS  = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;

  // Flash clock half period in ref_clk cycles; must exceed the two-flop input lag
  localparam int FLASH_HALF_CYC = 4;

  // Boot image layout
  localparam int          IMAGE_BYTES  = 256;
  localparam int          IMAGE_NIBS   = 2 * IMAGE_BYTES;
  localparam logic [23:0] IMAGE_ADDR   = 24'h000000;

  // Fast quad read sequence
  localparam logic [7:0]  QREAD_OPCODE = 8'heb;
  localparam int          OPCODE_BITS  = 8;
  localparam int          ADDR_NIBS    = 6;
  localparam int          DUMMY_NIBS   = 2;

  // Strap line position within the quad data bus
  localparam int          STRAP_BIT    = 1;

  typedef enum logic [3:0] {
    ST_HELD,
    ST_STARTUP,
    ST_SLAVE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_DONE
  } rbm_state_t;

endpackage : rbm_pkg

// ===== hdl/rbm_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a slow level or a clock well below ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rbm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // First stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule : rbm_sync
`default_nettype wire

// ===== hdl/rbm_boot_loader.sv
// Reset handling and boot-source selection: slave serial boot or quad flash boot.
// Assumes all pin inputs are asynchronous to ref_clk and pass the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module rbm_boot_loader (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       resetPinN,
  input  wire logic       clkPinIn,
  output logic            clkPinOut,
  output logic            clkPinOe,
  output logic            flashCsN,
  output logic            flashCsOe,
  input  wire logic [3:0] quadDataIn,
  output logic      [3:0] quadDataOut,
  output logic      [3:0] quadDataOe,
  input  wire logic       spiCsN,
  input  wire logic       spiMosi,
  output logic            spiMiso,
  output logic            spiMisoOe,
  output logic      [7:0] imageData,
  output logic            imageValid,
  output logic            bootDone,
  output logic            slaveMode,
  output logic            masterMode
);

  localparam logic [15:0] STARTUP_LAST = 16'(rbm_pkg::STARTUP_CYC - 1);
  localparam logic [2:0]  HALF_LAST    = 3'(rbm_pkg::FLASH_HALF_CYC - 1);
  localparam logic [15:0] OPC_LAST     = 16'(rbm_pkg::OPCODE_BITS - 1);
  localparam logic [15:0] ADDR_LAST    = 16'(rbm_pkg::ADDR_NIBS - 1);
  localparam logic [15:0] DUMMY_LAST   = 16'(rbm_pkg::DUMMY_NIBS - 1);
  localparam logic [15:0] NIB_LAST     = 16'(rbm_pkg::IMAGE_NIBS - 1);
  localparam logic [15:0] BYTE_LAST    = 16'(rbm_pkg::IMAGE_BYTES - 1);

  logic [7:0] syncVec;
  logic       rstPinS;
  logic       clkS;
  logic       csS;
  logic       mosiS;
  logic [3:0] dinS;

  rbm_sync #(
    .WIDTH (8)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn ({resetPinN, clkPinIn, spiCsN, spiMosi, quadDataIn}),
    .syncOut (syncVec)
  );

  assign rstPinS = syncVec[7];
  assign clkS    = syncVec[6];
  assign csS     = syncVec[5];
  assign mosiS   = syncVec[4];
  assign dinS    = syncVec[3:0];

  rbm_pkg::rbm_state_t state_q, state_d;
  logic [15:0] cnt_q,      cnt_d;
  logic [15:0] byteCnt_q,  byteCnt_d;
  logic [2:0]  div_q,      div_d;
  logic        sck_q,      sck_d;
  logic        clkPrev_q,  clkPrev_d;
  logic [7:0]  shift_q,    shift_d;
  logic [7:0]  data_q,     data_d;
  logic        valid_q,    valid_d;
  logic        done_q,     done_d;
  logic        slave_q,    slave_d;
  logic        master_q,   master_d;
  logic        csN_q,      csN_d;
  logic        csOe_q,     csOe_d;
  logic        clkOe_q,    clkOe_d;
  logic [3:0]  qOut_q,     qOut_d;
  logic [3:0]  qOe_q,      qOe_d;
  logic        misoOe_q,   misoOe_d;

  logic        halfTick;
  logic        riseNext;
  logic        fallNext;
  logic        hostEdge;
  logic [23:0] addrShift;

  always_comb begin
    halfTick  = (div_q == HALF_LAST);
    riseNext  = halfTick && !sck_q;
    fallNext  = halfTick && sck_q;
    hostEdge  = clkS && !clkPrev_q && !csS;
    addrShift = '0;
    state_d   = state_q;
    cnt_d     = cnt_q;
    byteCnt_d = byteCnt_q;
    div_d     = '0;
    sck_d     = sck_q;
    clkPrev_d = clkS;
    shift_d   = shift_q;
    data_d    = data_q;
    valid_d   = 1'b0;
    done_d    = done_q;
    slave_d   = slave_q;
    master_d  = master_q;

    if (!rstPinS) begin
      state_d   = rbm_pkg::ST_HELD;
      cnt_d     = '0;
      byteCnt_d = '0;
      sck_d     = 1'b0;
      shift_d   = '0;
      data_d    = '0;
      done_d    = 1'b0;
      slave_d   = 1'b0;
      master_d  = 1'b0;
    end else begin
      unique case (state_q)
        rbm_pkg::ST_HELD: begin
          state_d = rbm_pkg::ST_STARTUP;
          cnt_d   = '0;
        end
        rbm_pkg::ST_STARTUP: begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == STARTUP_LAST) begin
            cnt_d = '0;
            // One sample only; the flash line is free to toggle afterwards
            if (dinS[rbm_pkg::STRAP_BIT]) begin
              state_d = rbm_pkg::ST_SLAVE;
              slave_d = 1'b1;
            end else begin
              state_d  = rbm_pkg::ST_CMD;
              master_d = 1'b1;
            end
          end
        end
        rbm_pkg::ST_SLAVE: begin
          if (csS) begin
            // Deselect re-frames the byte boundary
            cnt_d = '0;
          end else if (hostEdge) begin
            shift_d = {mosiS, shift_q[7:1]};
            cnt_d   = cnt_q + 16'h0001;
            if (cnt_q[2:0] == 3'h7) begin
              cnt_d     = '0;
              data_d    = {mosiS, shift_q[7:1]};
              valid_d   = 1'b1;
              byteCnt_d = byteCnt_q + 16'h0001;
              if (byteCnt_q == BYTE_LAST) begin
                state_d = rbm_pkg::ST_DONE;
              end
            end
          end
        end
        rbm_pkg::ST_CMD,
        rbm_pkg::ST_ADDR,
        rbm_pkg::ST_DUMMY,
        rbm_pkg::ST_DATA: begin
          div_d = halfTick ? 3'h0 : div_q + 3'h1;
          if (halfTick) begin
            sck_d = !sck_q;
          end
          if (riseNext && state_q == rbm_pkg::ST_DATA) begin
            if (!cnt_q[0]) begin
              shift_d[3:0] = dinS;
            end else begin
              data_d    = {dinS, shift_q[3:0]};
              valid_d   = 1'b1;
              byteCnt_d = byteCnt_q + 16'h0001;
            end
          end
          if (fallNext) begin
            cnt_d = cnt_q + 16'h0001;
            unique case (state_q)
              rbm_pkg::ST_CMD: begin
                if (cnt_q == OPC_LAST) begin
                  state_d = rbm_pkg::ST_ADDR;
                  cnt_d   = '0;
                end
              end
              rbm_pkg::ST_ADDR: begin
                if (cnt_q == ADDR_LAST) begin
                  state_d = rbm_pkg::ST_DUMMY;
                  cnt_d   = '0;
                end
              end
              rbm_pkg::ST_DUMMY: begin
                if (cnt_q == DUMMY_LAST) begin
                  state_d = rbm_pkg::ST_DATA;
                  cnt_d   = '0;
                end
              end
              default: begin
                if (cnt_q == NIB_LAST) begin
                  state_d = rbm_pkg::ST_DONE;
                end
              end
            endcase
          end
        end
        rbm_pkg::ST_DONE: begin
          done_d = 1'b1;
          sck_d  = 1'b0;
        end
        default: begin
          state_d = rbm_pkg::ST_HELD;
        end
      endcase
    end

    // Pin drives follow the next state so they reach the pads as flops
    csN_d    = 1'b1;
    csOe_d   = master_d;
    clkOe_d  = master_d;
    qOut_d   = '0;
    qOe_d    = '0;
    misoOe_d = slave_d && !csS && state_d == rbm_pkg::ST_SLAVE;
    unique case (state_d)
      rbm_pkg::ST_CMD: begin
        csN_d     = 1'b0;
        qOe_d[0]  = 1'b1;
        qOut_d[0] = rbm_pkg::QREAD_OPCODE[3'(3'h7 - cnt_d[2:0])];
      end
      rbm_pkg::ST_ADDR: begin
        csN_d     = 1'b0;
        qOe_d     = 4'hf;
        addrShift = rbm_pkg::IMAGE_ADDR >> {3'(3'h5 - cnt_d[2:0]), 2'b00};
        qOut_d    = addrShift[3:0];
      end
      rbm_pkg::ST_DUMMY,
      rbm_pkg::ST_DATA: begin
        csN_d = 1'b0;
      end
      default: begin
        csN_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q   <= rbm_pkg::ST_HELD;
      cnt_q     <= '0;
      byteCnt_q <= '0;
      div_q     <= '0;
      sck_q     <= 1'b0;
      clkPrev_q <= 1'b0;
      shift_q   <= '0;
      data_q    <= '0;
      valid_q   <= 1'b0;
      done_q    <= 1'b0;
      slave_q   <= 1'b0;
      master_q  <= 1'b0;
      csN_q     <= 1'b1;
      csOe_q    <= 1'b0;
      clkOe_q   <= 1'b0;
      qOut_q    <= '0;
      qOe_q     <= '0;
      misoOe_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      byteCnt_q <= byteCnt_d;
      div_q     <= div_d;
      sck_q     <= sck_d;
      clkPrev_q <= clkPrev_d;
      shift_q   <= shift_d;
      data_q    <= data_d;
      valid_q   <= valid_d;
      done_q    <= done_d;
      slave_q   <= slave_d;
      master_q  <= master_d;
      csN_q     <= csN_d;
      csOe_q    <= csOe_d;
      clkOe_q   <= clkOe_d;
      qOut_q    <= qOut_d;
      qOe_q     <= qOe_d;
      misoOe_q  <= misoOe_d;
    end
  end

  // Boot image is receive-only, so the slave output line idles low
  assign spiMiso     = 1'b0;
  assign clkPinOut   = sck_q;
  assign clkPinOe    = clkOe_q;
  assign flashCsN    = csN_q;
  assign flashCsOe   = csOe_q;
  assign quadDataOut = qOut_q;
  assign quadDataOe  = qOe_q;
  assign spiMisoOe   = misoOe_q;
  assign imageData   = data_q;
  assign imageValid  = valid_q;
  assign bootDone    = done_q;
  assign slaveMode   = slave_q;
  assign masterMode  = master_q;

endmodule : rbm_boot_loader
`default_nettype wire

// ===== bench/rbm_boot_asserts.sv
// Port assertions for the boot loader.
// Assumes it is bound into rbm_boot_loader.
`timescale 1ns/1ps
`default_nettype none
module rbm_boot_asserts (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       resetPinN,
  input wire logic       clkPinOut,
  input wire logic       clkPinOe,
  input wire logic       flashCsN,
  input wire logic       flashCsOe,
  input wire logic [3:0] quadDataOe,
  input wire logic       imageValid,
  input wire logic       bootDone,
  input wire logic       slaveMode,
  input wire logic       masterMode
);
  logic [7:0] hiCnt_q, hiCnt_d;
  logic [8:0] vCnt_q, vCnt_d;
  // Saturates so a long boot never wraps into the start-up window
  always_comb begin
    hiCnt_d = !resetPinN ? 8'h00 : hiCnt_q + {7'h00, hiCnt_q != 8'hff};
    vCnt_d  = !resetPinN ? 9'h000 : vCnt_q + {8'h00, imageValid};
  end
  always_ff @(posedge ref_clk) begin
    hiCnt_q <= reset ? 8'h00 : hiCnt_d;
    vCnt_q  <= reset ? 9'h000 : vCnt_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  pin_held_a: assert property (!resetPinN [*6] |->
    !slaveMode && !masterMode && !bootDone && flashCsN) else $error("pin reset");
  startup_a: assert property ($rose(slaveMode || masterMode) |->
    hiCnt_q inside {[8'h64:8'h6b]}) else $error("start-up delay");
  slave_pins_a: assert property (slaveMode |->
    !clkPinOe && !flashCsOe && quadDataOe == 4'h0) else $error("slave pins");
  cs_mode_a: assert property ($fell(flashCsN) |-> ##[0:2] masterMode)
    else $error("select in slave");
  master_pins_a: assert property (masterMode && !flashCsN |-> clkPinOe && flashCsOe)
    else $error("master pins");
  sck_shape_a: assert property (disable iff (reset || !resetPinN)
    $rose(clkPinOut) |-> clkPinOut [*4] ##1 !clkPinOut) else $error("flash clock");
  done_cnt_a: assert property ($rose(bootDone) |-> vCnt_q == 9'h100)
    else $error("done count");
  mode_hold_a: assert property ($fell(slaveMode) || $fell(masterMode) |->
    hiCnt_q < 8'h06) else $error("mode lost");
  cover property (slaveMode && $rose(bootDone));
  cover property (masterMode && $rose(bootDone));
  cover property (!resetPinN && masterMode);
endmodule : rbm_boot_asserts
`default_nettype wire

// ===== bench/rbm_flash_model.sv
// Behavioural quad flash; image byte n is n xor KEY.
// Assumes select and clock are the resolved pin levels.
`timescale 1ns/1ps
`default_nettype none
module rbm_flash_model #(
  parameter logic [7:0] KEY = 8'h3c
) (
  input  wire logic       csN,
  input  wire logic       sck,
  input  wire logic [3:0] io,
  output logic            oe,
  output logic      [3:0] d
);
  int          rises = 0;
  int          falls = 0;
  logic [7:0]  op    = 8'h00;
  logic [23:0] addr  = 24'h000000;
  logic [7:0]  b;
  initial oe = 1'b0;
  always @(posedge csN) begin
    rises = 0;
    falls = 0;
    oe    = 1'b0;
  end
  always @(posedge sck) if (!csN) begin
    rises++;
    if (rises <= 8) op = {op[6:0], io[0]};
    else if (rises <= 14) addr = {addr[19:0], io};
  end
  // Answers only a proper quad read, like a real part
  always @(negedge sck) if (!csN) begin
    falls++;
    b  = 8'((falls - 16) / 2) ^ KEY;
    oe = falls >= 16 && op == rbm_pkg::QREAD_OPCODE && addr == rbm_pkg::IMAGE_ADDR;
    d  = falls[0] ? b[7:4] : b[3:0]; // Low nibble first
  end
endmodule : rbm_flash_model
`default_nettype wire

// ===== bench/rbm_boot_loader_tb_top.sv
// Bench: flash boot cut short, flash boot, then host boot.
// Assumes the flash model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module rbm_boot_loader_tb_top;
  logic       ref_clk = 1'b0, reset = 1'b1, hostSck = 1'b0, spiCsN = 1'b1, spiMosi = 1'b0;
  logic       resetPinN = 1'b0; // Low from power-up
  logic       strapLvl = 1'b1, toggle = 1'b0, clkPinOut, clkPinOe, flashCsN, flashCsOe;
  logic       spiMiso, spiMisoOe, imageValid, bootDone, slaveMode, masterMode, fOe;
  logic [3:0] qOut, qOe, fD;
  logic [7:0] imageData, key = 8'h00;
  int         nBytes = 0, cyc = 0, err_count = 0, checked = 0;
  wire logic       clkWire  = clkPinOe ? clkPinOut : hostSck;
  // Undriven lines other than the strap line wiggle so a stale level never passes for data
  wire logic [3:0] quadWire = (qOut & qOe) | (fD & ~qOe & {4{fOe}})
    | ({toggle, toggle, strapLvl, toggle} & ~qOe & {4{~fOe}});
  rbm_boot_loader dut (.ref_clk, .reset, .resetPinN, .clkPinIn(clkWire), .clkPinOut,
    .clkPinOe, .flashCsN, .flashCsOe, .quadDataIn(quadWire), .quadDataOut(qOut),
    .quadDataOe(qOe), .spiCsN, .spiMosi, .spiMiso, .spiMisoOe, .imageData, .imageValid,
    .bootDone, .slaveMode, .masterMode);
  rbm_flash_model flash (.csN(flashCsN | ~flashCsOe), .sck(clkWire), .io(quadWire),
    .oe(fOe), .d(fD));
  always #5 ref_clk = ~ref_clk; // Free-running clock
  // Read mid-cycle, where the design's outputs have settled
  always @(negedge ref_clk) begin
    toggle <= ~toggle;
    if (imageValid === 1'b1) begin
      check("imageData", 9'(imageData), 9'(8'(nBytes) ^ key));
      nBytes++;
    end
    cyc++;
    if (cyc == 45000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic boot_start(input logic strap);
    @(posedge ref_clk);
    #1 resetPinN = 1'b0;
    strapLvl = strap;
    key      = strap ? 8'ha5 : 8'h3c;
    nBytes   = 0;
    repeat (8) @(posedge ref_clk);
    #1 resetPinN = 1'b1; // Flash already settled
    for (int i = 0; i < 200 && (slaveMode | masterMode) !== 1'b1; i++) @(posedge ref_clk);
    #1;
    check("slaveMode", 9'(slaveMode), 9'(strap));
    check("masterMode", 9'(masterMode), 9'(!strap));
  endtask : boot_start
  // Link clock rests low between bits; data moves mid-low, flips after each run
  task automatic host_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      #31.25 spiMosi = b[i];
      #31.25 hostSck = 1'b1;
      #62.5 hostSck = 1'b0;
    end
    spiMosi = ~spiMosi;
  endtask : host_bits
  task automatic test_abort;
    boot_start(1'b0);
    repeat (300) @(posedge ref_clk);
    #1 resetPinN = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check("masterMode", 9'(masterMode), 9'h000);
    check("flashCsN", 9'(flashCsN), 9'h001);
    check("cut short", 9'(nBytes < 256 && bootDone === 1'b0), 9'h001);
  endtask : test_abort
  task automatic test_master;
    boot_start(1'b0);
    for (int i = 0; i < 5000 && bootDone !== 1'b1; i++) @(posedge ref_clk);
    #1;
    check("bytes", 9'(nBytes), 9'h100);
    check("flashCsN", 9'(flashCsN), 9'h001);
    check("spiMisoOe", 9'(spiMisoOe), 9'h000);
  endtask : test_master
  task automatic test_slave;
    boot_start(1'b1);
    #1000 spiCsN = 1'b0;
    #100;
    check("spiMisoOe", 9'(spiMisoOe), 9'h001);
    check("spiMiso", 9'(spiMiso), 9'h000);
    host_bits(8'h07, 3); // Partial byte, dropped when select rises
    #200 spiCsN = 1'b1;
    #100;
    check("spiMisoOe", 9'(spiMisoOe), 9'h000);
    #100 spiCsN = 1'b0;
    for (int i = 0; i < 256; i++) host_bits(8'(i) ^ 8'ha5, 8);
    strapLvl = 1'b0;
    #200 spiCsN = 1'b1;
    for (int i = 0; i < 50 && bootDone !== 1'b1; i++) @(posedge ref_clk);
    #1;
    check("bytes", 9'(nBytes), 9'h100);
    check("slaveMode", 9'(slaveMode), 9'h001);
  endtask : test_slave
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 reset = 1'b0;
    test_abort();
    test_master();
    test_slave();
    tally_and_finish();
  end
endmodule : rbm_boot_loader_tb_top
bind rbm_boot_loader rbm_boot_asserts chk (.ref_clk, .reset, .resetPinN, .clkPinOut,
  .clkPinOe, .flashCsN, .flashCsOe, .quadDataOe, .imageValid, .bootDone, .slaveMode,
  .masterMode);
`default_nettype wire
